// ==== rtl/sck_pkg.sv ====
package sck_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_SRC = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_DIV = 8'h10;
  localparam logic [7:0] OFS_PSEL = 8'h14;
  localparam logic [7:0] OFS_WSRC = 8'h18;
  // oscillator source codes
  localparam logic [1:0] SRC_IRC = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_RTC = 2'h2;
  localparam logic [1:0] SRC_BAD = 2'h3;
  // watchdog source codes
  localparam logic [1:0] WSRC_IRC = 2'h0;
  localparam logic [1:0] WSRC_RTC = 2'h1;
  localparam logic [1:0] WSRC_PCLK = 2'h2;
  // field layout
  localparam int CFG_N_LSB = 16;
  localparam int CFG_N_W = 8;
  localparam int CFG_M_LSB = 0;
  localparam int CFG_M_W = 15;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CON_BIT = 1;
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_CON_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int DIV_CPU_LSB = 0;
  localparam int DIV_USB_LSB = 8;
  localparam int DIV_W = 8;
  localparam int PSEL_W = 2;
  // reset values
  localparam logic [1:0] SRC_RST = SRC_IRC;
  localparam logic [7:0] N_RST = 8'h00;
  localparam logic [14:0] M_RST = 15'h0000;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [1:0] WSRC_RST = WSRC_IRC;
  // peripheral divider codes: 0 /4, 1 /1, 2 /2, 3 /8
  localparam logic [1:0] PSEL_RST = 2'h0;
  // timing: settle for four internal rc cycles at its nominal rate
  localparam int IRC_HZ = 4000000;
  localparam int REF_MHZ = 20;
  localparam int SETTLE_IRC_CYC = 4;
  localparam int SETTLE_NS = SETTLE_IRC_CYC * 1000 / (IRC_HZ / 1000000);
  localparam int SETTLE_CYC = (SETTLE_NS * REF_MHZ + 999) / 1000;
  // clock switch sequencer
  typedef enum logic [2:0] {
    SCK_IDLE = 3'h1,
    SCK_OFF = 3'h2,
    SCK_ON = 3'h4
  } sck_state_e;
endpackage : sck_pkg

// ==== rtl/sck_clock_ctrl.sv ====
// Summary of operation
// - software picks any of three oscillators
// - reset selects internal rc oscillator
// - rc oscillator timing assumes 4 MHz
// - cpu clock bypasses unless pll connected
// - each peripheral gets selectable clock divider
// - pre-divider N programmable one to 256
// - multiplier M programmable one to 32768
// - reset and power-down disable, bypass pll
// - pll output divided for cpu, usb
// - main oscillator direct or through pll
// - rc oscillator selectable for watchdog, pll
// - rtc oscillator selectable for pll, cpu
`timescale 1ns/1ns
module sck_clock_ctrl
  import sck_pkg::*;
#(
  parameter int NUM_PERIPH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic pll_lock_in,
  input wire logic power_down_in,
  output logic pll_enable_out,
  output logic [7:0] pll_pre_div_out,
  output logic [14:0] pll_mul_out,
  output logic [1:0] clk_src_sel_out,
  output logic pll_connect_out,
  output logic cpu_clk_gate_out,
  output logic [7:0] cpu_div_out,
  output logic [7:0] usb_div_out,
  output logic [1:0] wdt_src_sel_out,
  output logic [NUM_PERIPH-1:0] pclk_en_out
);

  localparam int PSEL_TOT = NUM_PERIPH * PSEL_W;
  localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: lock and power-down
  logic [1:0] lock_sync_reg;
  logic [1:0] pd_sync_reg;
  logic lock_s;
  logic pd_s;

  // two flops each, first stage only feeds second
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_sync_reg <= 2'h0;
      pd_sync_reg <= 2'h0;
    end else begin
      lock_sync_reg <= {lock_sync_reg[0], pll_lock_in};
      pd_sync_reg <= {pd_sync_reg[0], power_down_in};
    end
  end

  assign lock_s = lock_sync_reg[1];
  assign pd_s = pd_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // register file over classic wishbone
  logic [1:0] src_reg, src_next;
  logic [7:0] n_reg, n_next;
  logic [14:0] m_reg, m_next;
  logic en_reg, en_next;
  logic con_reg, con_next;
  logic [7:0] cdiv_reg, cdiv_next;
  logic [7:0] udiv_reg, udiv_next;
  logic [PSEL_TOT-1:0] psel_reg, psel_next;
  logic [1:0] wsrc_reg, wsrc_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic busy;

  // merge write data into old word by byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge

  logic [31:0] src_word, cfg_word, ctrl_word, stat_word;
  logic [31:0] div_word, psel_word, wsrc_word;
  logic [31:0] wv;

  // current register words, unused bits read zero
  always_comb begin
    src_word = {30'h0, src_reg};
    cfg_word = {8'h00, n_reg, 1'b0, m_reg};
    ctrl_word = 32'h0;
    ctrl_word[CTRL_EN_BIT] = en_reg;
    ctrl_word[CTRL_CON_BIT] = con_reg;
    stat_word = 32'h0;
    stat_word[STAT_EN_BIT] = en_reg;
    stat_word[STAT_CON_BIT] = con_reg;
    stat_word[STAT_LOCK_BIT] = lock_s;
    stat_word[STAT_BUSY_BIT] = busy;
    div_word = {16'h0, udiv_reg, cdiv_reg};
    psel_word = 32'(psel_reg);
    wsrc_word = {30'h0, wsrc_reg};
  end

  // next values of the software registers
  always_comb begin
    src_next = src_reg;
    n_next = n_reg;
    m_next = m_reg;
    en_next = en_reg;
    con_next = con_reg;
    cdiv_next = cdiv_reg;
    udiv_next = udiv_reg;
    psel_next = psel_reg;
    wsrc_next = wsrc_reg;
    rdat_next = rdat_reg;
    wv = 32'h0;
    ack_next = wb_cyc_in && wb_stb_in && !ack_reg;
    if (ack_next && !wb_we_in) begin
      unique case (wb_adr_in)
        OFS_SRC: rdat_next = src_word;
        OFS_CFG: rdat_next = cfg_word;
        OFS_CTRL: rdat_next = ctrl_word;
        OFS_STAT: rdat_next = stat_word;
        OFS_DIV: rdat_next = div_word;
        OFS_PSEL: rdat_next = psel_word;
        OFS_WSRC: rdat_next = wsrc_word;
        default: rdat_next = 32'h0;
      endcase
    end
    if (ack_next && wb_we_in) begin
      unique case (wb_adr_in)
        OFS_SRC: begin
          wv = merge(src_word, wb_dat_in, wb_sel_in);
          if (wv[1:0] != SRC_BAD) begin
            src_next = wv[1:0];
          end
        end
        OFS_CFG: begin
          wv = merge(cfg_word, wb_dat_in, wb_sel_in);
          n_next = wv[CFG_N_LSB +: CFG_N_W];
          m_next = wv[CFG_M_LSB +: CFG_M_W];
        end
        OFS_CTRL: begin
          wv = merge(ctrl_word, wb_dat_in, wb_sel_in);
          en_next = wv[CTRL_EN_BIT];
          // connect refused unless enabled and locked
          con_next = wv[CTRL_CON_BIT] && en_next && lock_s;
        end
        OFS_DIV: begin
          wv = merge(div_word, wb_dat_in, wb_sel_in);
          cdiv_next = wv[DIV_CPU_LSB +: DIV_W];
          udiv_next = wv[DIV_USB_LSB +: DIV_W];
        end
        OFS_PSEL: begin
          wv = merge(psel_word, wb_dat_in, wb_sel_in);
          psel_next = wv[PSEL_TOT-1:0];
        end
        OFS_WSRC: begin
          wv = merge(wsrc_word, wb_dat_in, wb_sel_in);
          if (wv[1:0] != SRC_BAD) begin
            wsrc_next = wv[1:0];
          end
        end
        default: wv = 32'h0;
      endcase
    end
    // lost lock drops the connection
    if (!lock_s) begin
      con_next = 1'b0;
    end
    // power-down switches pll off and bypasses it
    if (pd_s) begin
      en_next = 1'b0;
      con_next = 1'b0;
    end
  end

  // reset: rc oscillator, pll off and bypassed
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_reg <= SRC_RST;
      n_reg <= N_RST;
      m_reg <= M_RST;
      en_reg <= 1'b0;
      con_reg <= 1'b0;
      cdiv_reg <= DIV_RST;
      udiv_reg <= DIV_RST;
      psel_reg <= {NUM_PERIPH{PSEL_RST}};
      wsrc_reg <= WSRC_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      src_reg <= src_next;
      n_reg <= n_next;
      m_reg <= m_next;
      en_reg <= en_next;
      con_reg <= con_next;
      cdiv_reg <= cdiv_next;
      udiv_reg <= udiv_next;
      psel_reg <= psel_next;
      wsrc_reg <= wsrc_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock switch sequencer: gate off, settle, swap, settle, gate on
  sck_state_e st_reg, st_next;
  logic [1:0] asrc_reg, asrc_next;
  logic acon_reg, acon_next;
  logic gate_reg, gate_next;
  logic [7:0] cnt_reg, cnt_next;
  logic change;

  assign change = (src_reg != asrc_reg) || (con_reg != acon_reg);
  assign busy = (st_reg != SCK_IDLE);

  // next state of the sequencer
  always_comb begin
    st_next = st_reg;
    asrc_next = asrc_reg;
    acon_next = acon_reg;
    gate_next = gate_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      SCK_IDLE: begin
        if (change) begin
          gate_next = 1'b0;
          cnt_next = SETTLE_LOAD;
          st_next = SCK_OFF;
        end
      end
      SCK_OFF: begin
        if (cnt_reg == 8'h00) begin
          asrc_next = src_reg;
          acon_next = con_reg;
          cnt_next = SETTLE_LOAD;
          st_next = SCK_ON;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      SCK_ON: begin
        if (cnt_reg == 8'h00) begin
          gate_next = 1'b1;
          st_next = SCK_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: begin
        gate_next = 1'b0;
        cnt_next = SETTLE_LOAD;
        st_next = SCK_OFF;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= SCK_IDLE;
      asrc_reg <= SRC_RST;
      acon_reg <= 1'b0;
      gate_reg <= 1'b1;
      cnt_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      asrc_reg <= asrc_next;
      acon_reg <= acon_next;
      gate_reg <= gate_next;
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // peripheral clock enables, one divider each
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_pclk
      logic [2:0] pc_reg, pc_next;
      logic pe_reg, pe_next;
      logic [2:0] lim;

      // terminal count from the selected divide code
      always_comb begin
        unique case (psel_reg[gi*PSEL_W +: PSEL_W])
          2'h0: lim = 3'h3;
          2'h1: lim = 3'h0;
          2'h2: lim = 3'h1;
          2'h3: lim = 3'h7;
        endcase
        pe_next = (pc_reg >= lim);
        pc_next = (pc_reg >= lim) ? 3'h0 : pc_reg + 3'h1;
      end

      // divider counter and enable pulse
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pc_reg <= 3'h0;
          pe_reg <= 1'b0;
        end else begin
          pc_reg <= pc_next;
          pe_reg <= pe_next;
        end
      end

      assign pclk_en_out[gi] = pe_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_dat_out = rdat_reg;
  assign wb_ack_out = ack_reg;
  assign pll_enable_out = en_reg;
  assign pll_pre_div_out = n_reg;
  assign pll_mul_out = m_reg;
  assign clk_src_sel_out = asrc_reg;
  assign pll_connect_out = acon_reg;
  assign cpu_clk_gate_out = gate_reg;
  assign cpu_div_out = cdiv_reg;
  assign usb_div_out = udiv_reg;
  assign wdt_src_sel_out = wsrc_reg;

endmodule : sck_clock_ctrl

// ==== dv/sck_clock_ctrl_chk.sv ====
`timescale 1ns/1ns
module sck_clock_ctrl_chk
  import sck_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic power_down_in,
  input wire logic pll_enable_out,
  input wire logic [1:0] clk_src_sel_out,
  input wire logic pll_connect_out,
  input wire logic cpu_clk_gate_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  // bus handshake
  a_ack_due: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (
    wb_ack_out && !wb_we_in && wb_adr_in >= 8'h1C |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  ////////////////////////////////////////////////////////////
  // clock selection
  a_src_legal: assert property (clk_src_sel_out != SRC_BAD)
    else $error("illegal source applied");
  a_reset_state: assert property ($rose(rst_n_in) |->
    clk_src_sel_out == SRC_IRC && !pll_enable_out && !pll_connect_out
    && cpu_clk_gate_out)
    else $error("wrong state after reset");
  a_switch_gated: assert property (
    $changed(clk_src_sel_out) |-> !cpu_clk_gate_out)
    else $error("source changed with gate open");
  a_connect_gated: assert property (
    $rose(pll_connect_out) |-> !cpu_clk_gate_out && pll_enable_out)
    else $error("connect without gate or enable");
  a_gate_window: assert property (
    $fell(cpu_clk_gate_out) |-> !cpu_clk_gate_out [*8] ##33 cpu_clk_gate_out)
    else $error("gate window wrong");
  a_pd_off: assert property (
    power_down_in |-> ##[1:4] !pll_enable_out)
    else $error("pll on in power-down");
  // main scenarios seen
  c_switch: cover property ($fell(cpu_clk_gate_out));
  c_connect: cover property ($rose(pll_connect_out));
  c_read: cover property (wb_ack_out && !wb_we_in);
endmodule : sck_clock_ctrl_chk

// ==== dv/sck_clock_ctrl_tb.sv ====
`timescale 1ns/1ns
module sck_clock_ctrl_tb;
  import sck_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic lock = 1'b0;
  logic pd = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] lfsr = 32'h4A7AB23D;
  logic [31:0] rdat, dat_o;
  logic [31:0] mdl [0:7];
  logic ack, en, con, gate;
  logic [7:0] pre, cdiv, udiv, pclk;
  logic [14:0] mul;
  logic [1:0] src, wsrc;
  int bad_count = 0;
  int checked = 0;
  int cyc_n = 0;
  int per_div [4] = '{4, 1, 2, 8}; // cycles between pulses per code
  sck_clock_ctrl #(.NUM_PERIPH(8)) u_sck_clock_ctrl (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(req),
    .wb_stb_in(req), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack),
    .pll_lock_in(lock), .power_down_in(pd), .pll_enable_out(en),
    .pll_pre_div_out(pre), .pll_mul_out(mul), .clk_src_sel_out(src),
    .pll_connect_out(con), .cpu_clk_gate_out(gate), .cpu_div_out(cdiv),
    .usb_div_out(udiv), .wdt_src_sel_out(wsrc), .pclk_en_out(pclk));
  // clock and cycle count
  always #25 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) cyc_n <= cyc_n + 1;
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      OFS_SRC, OFS_CTRL, OFS_WSRC: return 32'h3;
      OFS_CFG: return 32'h00FF7FFF;
      OFS_DIV, OFS_PSEL: return 32'hFFFF;
      default: return 32'h0;
    endcase
  endfunction : msk
  // next value of the stimulus shift register
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // one classic cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rdat = dat_o;
    req <= 1'b0;
    if (ack !== 1'b1) begin
      bad_count++;
      stop_test();
    end
  endtask : bus
  // write and update the model
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & msk(a);
    bus(1'b1, a, d, s);
    if (!((a == OFS_SRC || a == OFS_WSRC) && d[1:0] == 2'h3))
      mdl[a[4:2]] = (mdl[a[4:2]] & ~m) | (d & m);
    if (a == OFS_CTRL && !(d[0] && lock))
      mdl[2][1] = 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    check(rdat, e);
  endtask : rdc
  task automatic wt(input logic v);
    int n;
    n = 0;
    while (gate !== v && n < 100) begin
      @(posedge ref_clk_in);
      n++;
    end
    check(32'(gate), 32'(v));
    if (gate !== v) stop_test();
  endtask : wt
  // follow one switch sequence
  task automatic settle(input logic [1:0] s, input logic c);
    int t0;
    wt(1'b0);
    t0 = cyc_n;
    bus(1'b0, OFS_STAT, 32'h0, 4'hF);
    check(32'(rdat[3]), 32'h1);
    wt(1'b1);
    check(32'(cyc_n - t0), 32'(2 * SETTLE_CYC));
    check(32'(src), 32'(s));
    check(32'(con), 32'(c));
  endtask : settle
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    for (int i = 0; i < 8; i++) mdl[i] = 32'h0;
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    check(32'({src, en, con, gate}), 32'h1);
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), mdl[i]);
    $display("test reset done");
    for (int j = 0; j < 3; j++) begin
      lfsr = next_rand(lfsr);
      wr(OFS_CFG, j == 0 ? 32'h00FF7FFF : j == 1 ? 32'h0 : lfsr, 4'hF);
      rdc(OFS_CFG, mdl[1]);
      check(32'({pre, mul}), 32'({mdl[1][23:16], mdl[1][14:0]}));
    end
    $display("test divider done");
    for (int j = 1; j < 4; j++) begin
      wr(OFS_SRC, 32'(j % 3), 4'hF);
      settle(2'(j % 3), 1'b0);
    end
    wr(OFS_SRC, 32'h3, 4'hF);
    rdc(OFS_SRC, mdl[0]);
    $display("test source done");
    // rc input, N 1, M 100: oscillator at 400 MHz
    wr(OFS_CFG, 32'h63, 4'hF);
    wr(OFS_CTRL, 32'h3, 4'hF);
    rdc(OFS_CTRL, mdl[2]);
    rdc(OFS_STAT, 32'h1);
    lock <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    rdc(OFS_STAT, 32'h5);
    wr(OFS_CTRL, 32'h3, 4'hF);
    settle(SRC_IRC, 1'b1);
    pd <= 1'b1;
    n = 0;
    while ((en !== 1'b0 || con !== 1'b0) && n < 100) begin
      @(posedge ref_clk_in);
      n++;
    end
    check(32'({en, con}), 32'h0);
    pd <= 1'b0;
    lock <= 1'b0;
    mdl[2] = 32'h0;
    wt(1'b1);
    rdc(OFS_CTRL, mdl[2]);
    $display("test pll done");
    lfsr = next_rand(lfsr);
    wr(OFS_DIV, lfsr, 4'hF);
    wr(OFS_DIV, ~lfsr, 4'h1);
    rdc(OFS_DIV, mdl[4]);
    check(32'({udiv, cdiv}), mdl[4]);
    for (int w = 0; w < 4; w++) begin
      wr(OFS_WSRC, 32'(w), 4'hF);
      rdc(OFS_WSRC, mdl[6]);
      check(32'(wsrc), mdl[6]);
    end
    $display("test watchdog select done");
    for (int c = 0; c < 4; c++) begin
      wr(OFS_PSEL, {16'h0, {8{c[1:0]}}}, 4'hF);
      repeat (10) @(posedge ref_clk_in);
      n = 0;
      while (pclk[0] !== 1'b1 && n < 20) begin
        @(posedge ref_clk_in);
        n++;
      end
      n = 0;
      do begin
        @(posedge ref_clk_in);
        n++;
      end while (pclk[0] !== 1'b1 && n < 20);
      check(32'(n), 32'(per_div[c]));
      check(32'(pclk), 32'hFF);
    end
    $display("test peripheral done");
    // second reset in mid-run, from a non-default state
    wr(OFS_SRC, 32'h1, 4'hF);
    settle(SRC_MAIN, 1'b0);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    check(32'({src, en, con, gate}), 32'h1);
    for (int i = 0; i < 8; i++) mdl[i] = 32'h0;
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), mdl[i]);
    $display("test second reset done");
    stop_test();
  end
endmodule : sck_clock_ctrl_tb
bind sck_clock_ctrl sck_clock_ctrl_chk u_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .power_down_in(power_down_in), .pll_enable_out(pll_enable_out),
  .clk_src_sel_out(clk_src_sel_out), .pll_connect_out(pll_connect_out),
  .cpu_clk_gate_out(cpu_clk_gate_out));
